//--- rtl/psd_pkg.sv
// constants and types shared by the pseudo-static memory host controller
package psd_pkg;
    localparam int ADDR_W          = 13;   // 8K byte-wide locations
    localparam int DATA_W          = 8;
    localparam int CLK_PERIOD_NS   = 8;
    // address set-up before select, in clock cycles
    localparam int ADDR_SETUP_CYC  = 1;
    // strobe cycles up to the first ready sample; an enable stays active one cycle more
    localparam int STROBE_CYC      = 2;
    // cycles of idle gap after release of all strobes
    localparam int GAP_CYC         = 1;
    localparam logic [3:0] CNT_ZERO = 4'h0;

    typedef enum logic [2:0] {
        PSD_IDLE    = 3'b000,
        PSD_SETUP   = 3'b001,
        PSD_SELECT  = 3'b010,
        PSD_STROBE  = 3'b011,
        PSD_WAIT    = 3'b100,
        PSD_RELEASE = 3'b101,
        PSD_REFRESH = 3'b110,
        PSD_GAP     = 3'b111
    } psd_state_t;

    // request kinds on the user port
    typedef enum logic [1:0] {
        PSD_OP_READ  = 2'b00,
        PSD_OP_WRITE = 2'b01,
        PSD_OP_ADDR  = 2'b10,
        PSD_OP_REFR  = 2'b11
    } psd_op_t;
endpackage

//--- rtl/psd_host.sv
// host controller driving a pseudo-static dynamic memory through its pins
import psd_pkg::*;

// Overview of operation
// - host drives select glitch-free from a flop
// - drop enables before next select assertion
// - write strobe after select, data valid
// - write strobe delayed one flop stage
// - never both enables in one cycle
// - address valid before select for address-only
// - host waits while ready is low, except in the sync variant
// - never select and refresh request together
// - refresh requests preferably on idle bus
module psd_host (
    // clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rstn_in,
    // user request port
    input  wire logic              req_valid_in,
    input  wire logic [1:0]        req_op_in,
    input  wire logic [ADDR_W-1:0] req_addr_in,
    input  wire logic [DATA_W-1:0] req_wdata_in,
    input  wire logic              sync_variant_in,
    output logic                   req_ready_out,
    output logic                   rsp_valid_out,
    output logic [DATA_W-1:0]      rsp_rdata_out,
    // memory pins
    output logic [ADDR_W-1:0]      mem_addr_out,
    output logic [DATA_W-1:0]      mem_data_out,
    output logic                   mem_data_oe_out,
    input  wire logic [DATA_W-1:0] mem_data_in,
    output logic                   chip_sel_n_out,
    output logic                   out_en_n_out,
    output logic                   wr_en_n_out,
    output logic                   refresh_request_out,
    input  wire logic              mem_ready_in
);

    typedef struct packed {
        psd_state_t          st;
        psd_op_t             op;
        logic [3:0]          cnt;
        logic                req_ready;
        logic                rsp_valid;
        logic [DATA_W-1:0]   rdata;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic                data_oe;
        logic                cs_n;
        logic                oe_n;
        logic                we_n;
        logic                refr;
    } psd_regs_t;

    psd_regs_t r;
    psd_regs_t next_r;

    function automatic logic [3:0] cyc(input int n);
        cyc = 4'(n);
    endfunction

    // decode of the request kind on the user port
    function automatic logic op_is_refr(input logic [1:0] op);
        op_is_refr = (psd_op_t'(op) == PSD_OP_REFR);
    endfunction

    function automatic logic op_is_write(input logic [1:0] op);
        op_is_write = (psd_op_t'(op) == PSD_OP_WRITE);
    endfunction

    always_comb begin
        next_r           = r;
        next_r.rsp_valid = 1'b0;
        case (r.st)

            // waiting for a request; address and data are registered here
            PSD_IDLE: begin
                if (req_valid_in && r.req_ready) begin
                    next_r.req_ready = 1'b0;
                    next_r.op        = psd_op_t'(req_op_in);
                    next_r.addr      = req_addr_in;
                    next_r.wdata     = req_wdata_in;
                    next_r.cnt       = cyc(ADDR_SETUP_CYC);
                    if (op_is_refr(req_op_in)) begin
                        // refresh only with select idle
                        next_r.refr = sync_variant_in;
                        next_r.cnt  = cyc(STROBE_CYC);
                        next_r.st   = PSD_REFRESH;
                    end else begin
                        // data driven early for writes
                        next_r.data_oe = op_is_write(req_op_in);
                        next_r.st      = PSD_SETUP;
                    end
                end
            end

            // address settles on the pins before select falls
            PSD_SETUP: begin
                next_r.cnt = r.cnt - 4'h1;
                if (r.cnt <= 4'h1) begin
                    // select from a single flop, one clean fall
                    next_r.cs_n = 1'b0;
                    next_r.st   = PSD_SELECT;
                end
            end

            // select is low; raise exactly one enable, or none
            PSD_SELECT: begin
                next_r.cnt = cyc(STROBE_CYC);
                // only one enable per select cycle
                if (r.op == PSD_OP_READ) begin
                    next_r.oe_n = 1'b0;
                end else if (r.op == PSD_OP_WRITE) begin
                    // strobe one flop stage after select
                    next_r.we_n = 1'b0;
                end
                next_r.st = PSD_STROBE;
            end

            // hold the enable for the strobe time, then for ready
            PSD_STROBE: begin
                if (r.cnt != CNT_ZERO) begin
                    next_r.cnt = r.cnt - 4'h1;
                end
                // stretch the access while the device is busy, unless in the sync variant
                if (r.cnt <= 4'h1 && (mem_ready_in || sync_variant_in)) begin
                    next_r.st = PSD_WAIT;
                end
            end

            // take read data and drop both enables while select is low
            PSD_WAIT: begin
                // sample read data while output enable still active
                next_r.rdata = mem_data_in;
                next_r.oe_n  = 1'b1;
                next_r.we_n  = 1'b1;
                next_r.st    = PSD_RELEASE;
            end

            // enables are already high, so select can rise cleanly
            PSD_RELEASE: begin
                next_r.cs_n      = 1'b1;
                next_r.data_oe   = 1'b0;
                next_r.rsp_valid = 1'b1;
                next_r.cnt       = cyc(GAP_CYC);
                next_r.st        = PSD_GAP;
            end

            // refresh request, raised in the sync variant only, held for the strobe time, select stays high
            PSD_REFRESH: begin
                next_r.cnt = r.cnt - 4'h1;
                if (r.cnt <= 4'h1) begin
                    next_r.refr      = 1'b0;
                    next_r.rsp_valid = 1'b1;
                    next_r.cnt       = cyc(GAP_CYC);
                    next_r.st        = PSD_GAP;
                end
            end

            // idle gap so the next select fall is a distinct edge
            PSD_GAP: begin
                next_r.cnt = r.cnt - 4'h1;
                if (r.cnt <= 4'h1) begin
                    next_r.req_ready = 1'b1;
                    next_r.st        = PSD_IDLE;
                end
            end

            // unreachable codes fall back to idle
            default: begin
                next_r.st = PSD_IDLE;
            end
        endcase
    end

    // reset parks every strobe inactive and the request port ready
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            r           <= '0;
            r.st        <= PSD_IDLE;
            r.req_ready <= 1'b1;
            r.cs_n      <= 1'b1;
            r.oe_n      <= 1'b1;
            r.we_n      <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // every output is a field of the registered state
    assign req_ready_out       = r.req_ready;
    assign rsp_valid_out       = r.rsp_valid;
    assign rsp_rdata_out       = r.rdata;
    assign mem_addr_out        = r.addr;
    assign mem_data_out        = r.wdata;
    assign mem_data_oe_out     = r.data_oe;
    assign chip_sel_n_out      = r.cs_n;
    assign out_en_n_out        = r.oe_n;
    assign wr_en_n_out         = r.we_n;
    assign refresh_request_out = r.refr;

endmodule

//--- bench/psd_host_assertions.sv
// pin protocol checks on the host controller's memory side
module psd_chk import psd_pkg::*; (
    input wire logic              ref_clk_in, rstn_in, sync_variant_in,
    input wire logic              chip_sel_n_out, out_en_n_out,
    input wire logic              wr_en_n_out, refresh_request_out,
    input wire logic              mem_data_oe_out, mem_ready_in,
    input wire logic [ADDR_W-1:0] mem_addr_out,
    input wire logic [DATA_W-1:0] mem_data_out);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence sel_fall; $fell(chip_sel_n_out); endsequence
    sequence refr_two; refresh_request_out[*2] ##1 !refresh_request_out;
    endsequence
    a_strobes_apart: assert property (out_en_n_out || wr_en_n_out)
        else $error("oe and we both low");
    a_idle_at_sel: assert property (
        sel_fall |-> out_en_n_out && wr_en_n_out)
        else $error("strobe low at select");
    a_we_in_sel: assert property (
        $fell(wr_en_n_out) |-> !chip_sel_n_out
        && mem_data_oe_out && $stable(mem_data_out)) else $error("early we");
    a_we_delayed: assert property (
        $fell(wr_en_n_out) |-> $past(mem_data_oe_out, 2))
        else $error("we not delayed");
    a_addr_settled: assert property (
        sel_fall |-> $stable(mem_addr_out))
        else $error("address moved at select");
    a_sel_clean: assert property (sel_fall |-> !chip_sel_n_out[*4])
        else $error("select glitch");
    a_wait_ready: assert property (sel_fall ##2 (!mem_ready_in &&
        !sync_variant_in) |-> ##2 !chip_sel_n_out) else $error("no wait");
    a_sel_refr_apart: assert property ($rose(refresh_request_out) |->
        chip_sel_n_out throughout refr_two) else $error("refresh overlap");
endmodule
bind psd_host psd_chk chk (.ref_clk_in, .rstn_in, .sync_variant_in,
    .chip_sel_n_out, .out_en_n_out, .wr_en_n_out, .refresh_request_out,
    .mem_data_oe_out, .mem_ready_in, .mem_addr_out, .mem_data_out);

//--- bench/psd_mem_model.sv
// behavioural pseudo-static memory answering the host pins
module psd_mem_model import psd_pkg::*; #(parameter int ROW_W = 7) (
    input  wire logic              clk_in, cs_n_in, oe_n_in, we_n_in,
    input  wire logic              refr_in, kick_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] din_in,
    output logic      [DATA_W-1:0] dout_out = '0,
    output logic                   rdy_out = 1'b1,
    output logic      [ROW_W-1:0]  row_out = '0);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [ADDR_W-1:0] lat;
    logic              cs_q = 1'b1;
    logic              rf_q = 1'b0;
    int                busy = 0;
    always @(posedge clk_in) begin
        cs_q <= cs_n_in;
        rf_q <= refr_in;
        busy <= kick_in ? 8 : (busy > 0 ? busy - 1 : 0);
        if (cs_q && !cs_n_in) begin
            lat <= addr_in;
            if (busy > 0) rdy_out <= 1'b0;
        end else if (busy == 0) rdy_out <= 1'b1;
        if (!we_n_in) mem[lat] <= din_in;
        if ((refr_in && !rf_q) || busy == 1)
            row_out <= row_out + 1'b1;
        // released bus toggles so a stale byte never looks valid
        dout_out <= oe_n_in ? ~dout_out : mem[lat];
    end
endmodule

//--- bench/tb_top.sv
// self-checking bench for the pseudo-static memory host controller
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import psd_pkg::*;
    logic clk = 0, rstn = 0, vld = 0, sync = 0, kick = 0;
    logic [1:0] op = '0;
    logic [ADDR_W-1:0] addr = '0, maddr;
    logic [DATA_W-1:0] wd = '0, rd, mdo, mdi;
    logic rdy, rsp, cs_n, oe_n, we_n, refr, mrdy, doe;
    logic [6:0] row;
    int n_fail = 0, n_checks = 0, cyc = 0, lat;
    psd_host DUT (.ref_clk_in(clk), .rstn_in(rstn), .req_valid_in(vld),
        .req_op_in(op), .req_addr_in(addr), .req_wdata_in(wd),
        .sync_variant_in(sync), .req_ready_out(rdy), .rsp_valid_out(rsp),
        .rsp_rdata_out(rd), .mem_addr_out(maddr), .mem_data_out(mdo),
        .mem_data_oe_out(doe), .mem_data_in(mdi), .chip_sel_n_out(cs_n),
        .out_en_n_out(oe_n), .wr_en_n_out(we_n),
        .refresh_request_out(refr), .mem_ready_in(mrdy));
    psd_mem_model mem (.clk_in(clk), .cs_n_in(cs_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .refr_in(refr), .kick_in(kick), .addr_in(maddr),
        .din_in(mdo), .dout_out(mdi), .rdy_out(mrdy), .row_out(row));
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        if (++cyc == 3000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one request; lat counts edges until the answer pulse is sampled
    task automatic req(input logic [1:0] k, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        while (rdy !== 1'b1) @(posedge clk);
        vld <= 1'b1; op <= k; addr <= a; wd <= d;
        @(posedge clk);
        vld <= 1'b0;
        lat = 0;
        do begin @(posedge clk); lat++; end while (rsp !== 1'b1 && lat < 40);
    endtask
    task automatic t_write_read;
        logic [ADDR_W-1:0] al [3] = '{13'h0000, 13'h1fff, 13'h0aaa};
        foreach (al[i]) begin
            req(PSD_OP_WRITE, al[i], 8'h5a ^ al[i][7:0]);
            check(16'(lat), 16'h7);
        end
        foreach (al[i]) begin
            req(PSD_OP_READ, al[i], 8'h00);
            check(16'(rd), 16'(8'h5a ^ al[i][7:0]));
        end
    endtask
    task automatic t_addr_only;
        req(PSD_OP_ADDR, 13'h0aaa, 8'h33);
        check(16'(lat), 16'h7);
        req(PSD_OP_READ, 13'h0aaa, 8'h00);
        check(16'(rd), 16'hf0);
    endtask
    task automatic t_collide;
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        req(PSD_OP_READ, 13'h1fff, 8'h00);
        check(16'(lat > 7), 16'h1);
        check(16'(rd), 16'ha5);
    endtask
    task automatic t_sync_refresh;
        logic [6:0] r0;
        sync <= 1'b1;
        @(posedge clk);
        r0 = row;
        req(PSD_OP_REFR, '0, 8'h00);
        check(16'(lat), 16'h3);
        req(PSD_OP_REFR, '0, 8'h00);
        check(16'(7'(row - r0)), 16'h2);
        req(PSD_OP_READ, 13'h0000, 8'h00);
        check(16'(rd), 16'h5a);
        sync <= 1'b0;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_write_read();
        t_addr_only();
        t_collide();
        t_sync_refresh();
        conclude();
    end
endmodule
